// ===== red_defs.vh
// register map, field layout and fixed latency constants of the delay block
`ifndef RED_DEFS_VH
`define RED_DEFS_VH

// register byte offsets
`define RED_OFF_RATIO       8'h3C
`define RED_OFF_DELAY       8'h40
`define RED_OFF_FILL        8'h44
`define RED_OFF_LATENCY     8'h48
`define RED_OFF_IRQ_STAT    8'h4C
`define RED_OFF_IRQ_MASK    8'h50

// field positions
`define RED_RATIO_W         16
`define RED_DLY_W           24
`define RED_FRESH_BIT       31
`define RED_FILL_BYTE_BIT   8
`define RED_IRQ_MEAS_BIT    0
`define RED_IRQ_OVF_BIT     1

// reset values
`define RED_RATIO_RST       16'h0000
`define RED_MASK_RST        2'h0

// transceiver latency in hundredths of a core cycle, per device group
`define RED_XRX_G0          10'h1D1
`define RED_XRX_G1          10'h28A
`define RED_XTX_G0          10'h14F
`define RED_XTX_G1          10'h15E

// core path latency in tenths of a core cycle
`define RED_CRX_BASE        6'h32
`define RED_CRX_G1_FAST     6'h1E
`define RED_CTX_BASE        6'h2D
`define RED_CTX_G0_FAST     6'h32
`define RED_CTX_G1_FAST     6'h28

`endif

// ===== red_elastic.v
// receive elastic buffer: written on recovered clock, read on core clock
`timescale 1ns/1ps
`default_nettype none

module red_elastic #(
   parameter AW = 4,
   parameter DW = 32
) (
   // write side, recovered receive clock
   input  wire          wr_clk,
   input  wire          wr_en,
   input  wire [DW-1:0] wr_data,
   output wire          full,
   // read side, core clock
   input  wire          rd_clk,
   input  wire          rst_n,
   input  wire          rd_en,
   output wire [DW-1:0] rd_data,
   output wire          empty,
   output wire [AW:0]   rd_count
);

   reg  [DW-1:0] mem [0:(1<<AW)-1];  // word storage
   reg  [AW:0]   wbin_q;             // write pointer, binary
   reg  [AW:0]   wgray_q;            // write pointer, gray
   reg  [AW:0]   rbin_q;             // read pointer, binary
   reg  [AW:0]   rgray_q;            // read pointer, gray
   wire [AW:0]   wgray_s;            // write gray in read domain
   wire [AW:0]   rgray_s;            // read gray in write domain
   wire [AW:0]   wbin_nx;
   wire [AW:0]   rbin_nx;
   reg  [AW:0]   wbin_s;             // decoded write pointer, read side
   integer       i;

   assign wbin_nx = wbin_q + {{AW{1'b0}}, 1'b1};
   assign rbin_nx = rbin_q + {{AW{1'b0}}, 1'b1};

   // write side owns the array and the write pointer
   always @(posedge wr_clk or negedge rst_n) begin
      if (!rst_n) begin
         wbin_q  <= {(AW+1){1'b0}};
         wgray_q <= {(AW+1){1'b0}};
      end else if (wr_en && !full) begin
         wbin_q  <= wbin_nx;
         wgray_q <= wbin_nx ^ (wbin_nx >> 1);
      end
   end

   // storage has no reset so it maps onto memory
   always @(posedge wr_clk) begin
      if (wr_en && !full) begin
         mem[wbin_q[AW-1:0]] <= wr_data;
      end
   end

   // read side pointer
   always @(posedge rd_clk or negedge rst_n) begin
      if (!rst_n) begin
         rbin_q  <= {(AW+1){1'b0}};
         rgray_q <= {(AW+1){1'b0}};
      end else if (rd_en && !empty) begin
         rbin_q  <= rbin_nx;
         rgray_q <= rbin_nx ^ (rbin_nx >> 1);
      end
   end

   // gray pointers cross so that only one bit moves per step
   red_sync #(.W(AW+1)) u_wsync (
      .clk   (rd_clk),
      .rst_n (rst_n),
      .d     (wgray_q),
      .q     (wgray_s)
   );
   red_sync #(.W(AW+1)) u_rsync (
      .clk   (wr_clk),
      .rst_n (rst_n),
      .d     (rgray_q),
      .q     (rgray_s)
   );

   // gray to binary of the crossed write pointer
   always @* begin
      wbin_s[AW] = wgray_s[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
         wbin_s[i] = wbin_s[i+1] ^ wgray_s[i];
      end
   end

   assign full     = (wgray_q == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
   assign empty    = (rgray_q == wgray_s);
   assign rd_count = wbin_s - rbin_q;
   assign rd_data  = mem[rbin_q[AW-1:0]];

endmodule // red_elastic

`default_nettype wire

// ===== red_rx_src.sv
// recovered clock and word source standing in for the link receiver
`timescale 1ns/1ps
`default_nettype none

module red_rx_src (
   // recovered clock and word stream
   output var logic        rx_clk,
   output var logic        rx_valid,
   output var logic [31:0] rx_data
);
   // divider free reference
   // free running, a little slower than core so the buffer never fills
   initial begin
      rx_clk   = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 32'h0000_0000;
      forever #10.5 rx_clk = ~rx_clk;
   end

   // one word on the next recovered clock edge
   task automatic send(input logic [31:0] w);
      @(posedge rx_clk);
      rx_valid <= 1'b1;
      rx_data  <= w;
   endtask

   // gap: data inverted so a stale word is never mistaken for new
   task automatic idle();
      @(posedge rx_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
   endtask
endmodule // red_rx_src
`default_nettype wire

// ===== red_sync.v
// three stage synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module red_sync #(
   parameter W = 1
) (
   // destination clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // asynchronous input and settled output
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] s1_q;   // metastable stage, read only by s2
   reg [W-1:0] s2_q;   // second stage
   reg [W-1:0] s3_q;   // third stage

   // shift chain; a change only passes once two stages have seen it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end

endmodule // red_sync

`default_nettype wire

// ===== red_top.v
// receive elastic buffer with delay measurement and apb status registers
//
// Behaviour
// - buffer written on rx clock, read on core
// - delay measured on separate measure clock
// - resolution set by N versus M
// - fill register reports stored word count
// - latest delay published while N nonzero
// - fresh flag set on update, read clears
// - delay count divided by N gives cycles
// - ratio at 0x3C, delay at 0x40
// - transceiver receive latency per device group
// - transceiver transmit latency per device group
// - rx core latency five, three when fast in group 1
// - tx core latency by rate and group
// - transceiver alignment latency is deterministic
// - nonzero byte shift adds one cycle
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "red_defs.vh"

module red_top #(
   parameter AW        = 4,   // log2 of buffer depth in words
   parameter DEV_GROUP = 0,   // 0 first device group, 1 second
   parameter MARK_W    = 4    // one marked word every 2**MARK_W
) (
   // apb slave, core clock domain
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // interrupt
   output reg         irq,
   // receive side, recovered clock domain
   input  wire        rx_clk,
   input  wire        rx_valid,
   input  wire [31:0] rx_data,
   // byte shift detected by the receiver, asynchronous level
   input  wire        rx_byte_shift,
   // line rate above the base rate, asynchronous level
   input  wire        rate_fast,
   // dedicated measurement clock
   input  wire        measure_clock,
   // core side output
   output reg         core_valid,
   output reg  [31:0] core_data
);

   // ---------------- receive clock domain ----------------
   wire              buf_full;       // buffer full, rx side
   wire              wr_take;        // word accepted into buffer
   reg  [MARK_W-1:0] wr_seq_q;       // counts accepted words
   reg               wr_mark_tog_q;  // toggles on each marked write
   reg               ovf_tog_q;      // toggles on each dropped word

   assign wr_take = rx_valid && !buf_full;

   // mark one word in 2**MARK_W; only one marked word is ever in flight
   // because the buffer is no deeper than the marking interval
   always @(posedge rx_clk or negedge presetn) begin
      if (!presetn) begin
         wr_seq_q      <= {MARK_W{1'b0}};
         wr_mark_tog_q <= 1'b0;
         ovf_tog_q     <= 1'b0;
      end else begin
         if (wr_take) begin
            wr_seq_q <= wr_seq_q + {{(MARK_W-1){1'b0}}, 1'b1};
            if (wr_seq_q == {MARK_W{1'b0}}) begin
               wr_mark_tog_q <= ~wr_mark_tog_q;
            end
         end
         // overflow is an event for the interrupt logic
         if (rx_valid && buf_full) begin
            ovf_tog_q <= ~ovf_tog_q;
         end
      end
   end

   // ---------------- elastic buffer ----------------
   wire        buf_empty;    // nothing to read
   wire [31:0] buf_rdata;    // head word
   wire [AW:0] buf_count;    // words held, core domain
   wire        rd_take;      // head word taken
   reg  [MARK_W-1:0] rd_seq_q;     // counts words read
   reg               rd_mark_tog_q; // toggles on each marked read

   red_elastic #(.AW(AW), .DW(32)) u_buf (
      .wr_clk   (rx_clk),
      .wr_en    (wr_take),
      .wr_data  (rx_data),
      .full     (buf_full),
      .rd_clk   (pclk),
      .rst_n    (presetn),
      .rd_en    (rd_take),
      .rd_data  (buf_rdata),
      .empty    (buf_empty),
      .rd_count (buf_count)
   );

   // drain continuously; the buffer only absorbs phase and rate wander
   assign rd_take = !buf_empty;

   // ---------------- level inputs into core domain ----------------
   wire byte_shift_s;   // settled byte shift level
   wire rate_fast_s;    // settled line rate level
   wire ovf_tog_s;      // settled overflow toggle
   wire pub_tog_s;      // settled publish toggle
   reg  pub_tog_q;      // toggles on each publish
   reg  [`RED_RATIO_W-1:0] ratio_q;     // programmed N

   red_sync #(.W(4)) u_core_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({rx_byte_shift, rate_fast, ovf_tog_q, pub_tog_q}),
      .q     ({byte_shift_s, rate_fast_s, ovf_tog_s, pub_tog_s})
   );

   // ---------------- core side read path ----------------
   reg        hold_valid_q;  // word held for the byte shift cycle
   reg [31:0] hold_data_q;

   // read marks, and the output stage with optional extra cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_seq_q      <= {MARK_W{1'b0}};
         rd_mark_tog_q <= 1'b0;
         hold_valid_q  <= 1'b0;
         hold_data_q   <= 32'h0000_0000;
         core_valid    <= 1'b0;
         core_data     <= 32'h0000_0000;
      end else begin
         if (rd_take) begin
            rd_seq_q <= rd_seq_q + {{(MARK_W-1){1'b0}}, 1'b1};
            if (rd_seq_q == {MARK_W{1'b0}}) begin
               rd_mark_tog_q <= ~rd_mark_tog_q;
            end
         end
         hold_valid_q <= rd_take;
         hold_data_q  <= buf_rdata;
         if (byte_shift_s) begin
            core_valid <= hold_valid_q;
            core_data  <= hold_data_q;
         end else begin
            core_valid <= rd_take;
            core_data  <= buf_rdata;
         end
      end
   end

   // ---------------- measurement clock domain ----------------
   wire [`RED_RATIO_W-1:0] ratio_m;     // ratio N seen by this domain
   wire                    wmark_m;     // write mark toggle
   wire                    rmark_m;     // read mark toggle
   wire                    pending_m;   // a marked word is in the buffer
   reg                     pend_q;      // pending, previous cycle
   reg  [`RED_DLY_W-1:0]   span_q;      // measure periods of this word
   reg  [`RED_DLY_W-1:0]   acc_q;       // sum over samples so far
   reg  [`RED_RATIO_W-1:0] samp_q;      // samples summed so far
   reg  [`RED_DLY_W-1:0]   result_q;    // published sum, held stable
   wire [`RED_DLY_W-1:0]   sum_nx;

   // the ratio is quasi static, written before the clock is started
   red_sync #(.W(`RED_RATIO_W + 2)) u_meas_sync (
      .clk   (measure_clock),
      .rst_n (presetn),
      .d     ({ratio_q, wr_mark_tog_q, rd_mark_tog_q}),
      .q     ({ratio_m, wmark_m, rmark_m})
   );

   // timing taken on the measure clock
   assign pending_m = wmark_m ^ rmark_m;
   assign sum_nx    = acc_q + span_q;

   // sum of N samples, so sum over N is the average
   // phase sweep of the two clocks sets the resolution
   always @(posedge measure_clock or negedge presetn) begin
      if (!presetn) begin
         pend_q    <= 1'b0;
         span_q    <= {`RED_DLY_W{1'b0}};
         acc_q     <= {`RED_DLY_W{1'b0}};
         samp_q    <= {`RED_RATIO_W{1'b0}};
         result_q  <= {`RED_DLY_W{1'b0}};
         pub_tog_q <= 1'b0;
      end else begin
         pend_q <= pending_m;
         if (pending_m) begin
            span_q <= span_q + {{(`RED_DLY_W-1){1'b0}}, 1'b1};
         end else if (pend_q) begin
            span_q <= {`RED_DLY_W{1'b0}};
         end
         if (ratio_m == {`RED_RATIO_W{1'b0}}) begin
            // no ratio programmed: stay idle
            acc_q  <= {`RED_DLY_W{1'b0}};
            samp_q <= {`RED_RATIO_W{1'b0}};
         end else if (pend_q && !pending_m) begin
            // publish after each group of N
            if (samp_q == ratio_m - {{(`RED_RATIO_W-1){1'b0}}, 1'b1}) begin
               result_q  <= sum_nx;
               pub_tog_q <= ~pub_tog_q;
               acc_q     <= {`RED_DLY_W{1'b0}};
               samp_q    <= {`RED_RATIO_W{1'b0}};
            end else begin
               acc_q  <= sum_nx;
               samp_q <= samp_q + {{(`RED_RATIO_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // ---------------- apb register file ----------------
   reg  [`RED_DLY_W-1:0]   delay_q;     // latest delay count
   reg                     fresh_q;     // new value since last read
   reg                     pub_seen_q;  // publish toggle already taken
   reg                     ovf_seen_q;  // overflow toggle already taken
   reg  [1:0]              irq_stat_q;  // sticky events
   reg  [1:0]              irq_mask_q;  // event enables
   wire                    acc_ok;      // access phase completing
   wire                    wr_ok;
   wire                    rd_ok;
   wire                    new_meas;    // publish arrived this cycle
   wire                    new_ovf;     // overflow arrived this cycle
   wire [1:0]              ev;
   reg  [31:0]             rd_mux;      // read data select
   reg                     mapped;      // address decodes
   wire [9:0]              lat_xrx;
   wire [9:0]              lat_xtx;
   reg  [5:0]              lat_crx;
   reg  [5:0]              lat_ctx;

   assign acc_ok   = psel && penable && pready;
   assign wr_ok    = acc_ok && pwrite;
   assign rd_ok    = acc_ok && !pwrite;
   assign new_meas = pub_tog_s ^ pub_seen_q;
   assign new_ovf  = ovf_tog_s ^ ovf_seen_q;
   assign ev       = {new_ovf, new_meas};

   assign lat_xrx = (DEV_GROUP != 0) ? `RED_XRX_G1 : `RED_XRX_G0;
   assign lat_xtx = (DEV_GROUP != 0) ? `RED_XTX_G1 : `RED_XTX_G0;

   // core path latencies depend on group and line rate
   always @* begin
      lat_crx = `RED_CRX_BASE;
      lat_ctx = `RED_CTX_BASE;
      if (rate_fast_s) begin
         if (DEV_GROUP != 0) begin
            lat_crx = `RED_CRX_G1_FAST;
            lat_ctx = `RED_CTX_G1_FAST;
         end else begin
            lat_ctx = `RED_CTX_G0_FAST;
         end
      end
   end

   // read data decode; unused bits read as zero
   always @* begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `RED_OFF_RATIO: begin
            rd_mux[`RED_RATIO_W-1:0] = ratio_q;
         end
         `RED_OFF_DELAY: begin
            rd_mux[`RED_DLY_W-1:0]  = delay_q;
            rd_mux[`RED_FRESH_BIT]  = fresh_q;
         end
         `RED_OFF_FILL: begin
            rd_mux[AW:0]               = buf_count;
            rd_mux[`RED_FILL_BYTE_BIT] = byte_shift_s;
         end
         `RED_OFF_LATENCY: begin
            rd_mux = {lat_ctx, lat_crx, lat_xtx, lat_xrx};
         end
         `RED_OFF_IRQ_STAT: begin
            rd_mux[1:0] = irq_stat_q;
         end
         `RED_OFF_IRQ_MASK: begin
            rd_mux[1:0] = irq_mask_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // bus handshake: one wait state, answer registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped;
         end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // registers, flags and interrupt; a new event beats a clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_q    <= `RED_RATIO_RST;
         delay_q    <= {`RED_DLY_W{1'b0}};
         fresh_q    <= 1'b0;
         pub_seen_q <= 1'b0;
         ovf_seen_q <= 1'b0;
         irq_stat_q <= 2'h0;
         irq_mask_q <= `RED_MASK_RST;
         irq        <= 1'b0;
      end else begin
         pub_seen_q <= pub_tog_s;
         ovf_seen_q <= ovf_tog_s;
         if (wr_ok && paddr == `RED_OFF_RATIO) begin
            ratio_q <= pwdata[`RED_RATIO_W-1:0];
         end
         if (wr_ok && paddr == `RED_OFF_IRQ_MASK) begin
            irq_mask_q <= pwdata[1:0];
         end
         if (new_meas) begin
            delay_q <= result_q;
         end
         if (new_meas) begin
            fresh_q <= 1'b1;
         end else if (rd_ok && paddr == `RED_OFF_DELAY) begin
            fresh_q <= 1'b0;
         end
         // write one to clear; events arriving now stay set
         if (wr_ok && paddr == `RED_OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule // red_top

`default_nettype wire

// ===== red_top_chk.sv
// concurrent checks on the apb, interrupt and rate select ports of red_top
`timescale 1ns/1ps
`default_nettype none
`include "red_defs.vh"

module red_top_chk #(
   parameter AW        = 4,
   parameter DEV_GROUP = 0,
   parameter MARK_W    = 4
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // interrupt and rate select
   input wire logic        irq,
   input wire logic        rate_fast
);
   logic        fast_q;     // rate select seen last cycle
   logic [2:0]  age_q;      // cycles since rate select moved, saturating
   logic [15:0] ratio_q;    // last ratio written by software
   logic        mapped;     // address decodes to a register

   assign mapped = paddr inside {`RED_OFF_RATIO, `RED_OFF_DELAY,
      `RED_OFF_FILL, `RED_OFF_LATENCY, `RED_OFF_IRQ_STAT,
      `RED_OFF_IRQ_MASK};

   // expected latency word; the pin is synchronised, so only trust it
   // once it has been quiet for a while
   function automatic logic [31:0] lat(input logic fast);
      lat[9:0]   = DEV_GROUP ? `RED_XRX_G1 : `RED_XRX_G0;
      lat[19:10] = DEV_GROUP ? `RED_XTX_G1 : `RED_XTX_G0;
      lat[25:20] = (DEV_GROUP && fast) ? `RED_CRX_G1_FAST : `RED_CRX_BASE;
      lat[31:26] = !fast ? `RED_CTX_BASE :
                   DEV_GROUP ? `RED_CTX_G1_FAST : `RED_CTX_G0_FAST;
   endfunction

   // track rate pin age and the ratio software wrote
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_q  <= 1'b0;
         age_q   <= 3'h0;
         ratio_q <= `RED_RATIO_RST;
      end else begin
         fast_q <= rate_fast;
         if (rate_fast != fast_q)
            age_q <= 3'h0;
         else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
         if (psel && penable && pready && pwrite && paddr == `RED_OFF_RATIO)
            ratio_q <= pwdata[15:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // access phase taken, and a write of zero to the mask
   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_mask_off;
      psel && penable && pready && pwrite &&
      paddr == `RED_OFF_IRQ_MASK && pwdata[1:0] == 2'h0;
   endsequence

   a_ready_after_take:
      assert property (s_take |=> pready) else $error("no pready");
   a_ready_one_pulse:
      assert property (pready |=> !pready) else $error("pready held");
   a_ready_has_cause:
      assert property (!(psel && penable && !pready) |=> !pready)
      else $error("pready without access");
   a_err_on_unmapped:
      assert property (s_take ##0 !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_no_err_mapped:
      assert property (s_take ##0 mapped |=> !pslverr)
      else $error("mapped access refused");
   a_idle_read_zero:
      assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   a_latency_word:
      assert property (s_take ##0 (!pwrite && paddr == `RED_OFF_LATENCY
         && age_q == 3'h7) |=> prdata == lat(fast_q))
      else $error("latency word wrong");
   a_ratio_readback:
      assert property (s_take ##0 (!pwrite && paddr == `RED_OFF_RATIO)
         |=> prdata == {16'h0000, ratio_q})
      else $error("ratio readback wrong");
   a_irq_mask_off:
      assert property (s_mask_off |-> ##2 !irq)
      else $error("irq with mask cleared");
endmodule // red_top_chk

bind red_top red_top_chk #(.AW(AW), .DEV_GROUP(DEV_GROUP),
   .MARK_W(MARK_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq), .rate_fast(rate_fast));
`default_nettype wire

// ===== test_rx_elastic_delay_measure.sv
// self-checking bench for the receive buffer delay block
`timescale 1ns/1ps
`default_nettype none
`include "red_defs.vh"

module test_rx_elastic_delay_measure;
   localparam logic [31:0] LAT0 = {`RED_CTX_BASE, `RED_CRX_BASE,
      `RED_XTX_G0, `RED_XRX_G0};
   localparam logic [31:0] LAT1 = {`RED_CTX_G0_FAST, `RED_CRX_BASE,
      `RED_XTX_G0, `RED_XRX_G0};
   // stimulus
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        rx_byte_shift, rate_fast, measure_clock;
   // design outputs
   wire  [31:0] prdata, core_data;
   wire         pready, pslverr, irq, core_valid;
   wire         rx_clk, rx_valid;
   wire  [31:0] rx_data;
   // bookkeeping
   int          mismatches, samples_checked, n, i;
   logic [31:0] seed, w, last_rd;
   logic [64:0] apb_q[$];   // {error, mask, expected} per transfer
   logic [31:0] core_q[$];  // words in arrival order

   red_top #(.AW(4), .DEV_GROUP(0), .MARK_W(4)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .rx_clk(rx_clk),
      .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_byte_shift(rx_byte_shift), .rate_fast(rate_fast),
      .measure_clock(measure_clock), .core_valid(core_valid),
      .core_data(core_data));
   red_rx_src u_src (.rx_clk(rx_clk), .rx_valid(rx_valid),
      .rx_data(rx_data));

   // core clock 20 ns; measure clock M/N = 2/2, phase unrelated
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      measure_clock = 1'b0;
      #3;
      forever #10 measure_clock = ~measure_clock;
   end

   task automatic chk(input string what, input logic [31:0] e,
         input logic [31:0] got);
      samples_checked++;
      if (got !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one apb transfer; expectation noted before the request goes out
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] m,
         input logic [31:0] e, input logic er);
      int k;
      apb_q.push_back({er, m, e & m});
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      last_rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k == 50)
         chk("pready wait", 1, 0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      apb(1'b0, a, 0, m, e, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 0, 0, 1'b0);
   endtask
   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq !== lvl && k < 100) begin
         @(posedge pclk);
         k++;
      end
      chk("irq", {31'h0, lvl}, {31'h0, irq});
   endtask

   // apb monitor: oldest note against each answer
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (apb_q.size() == 0)
            chk("apb answer", 0, 1);
         else begin
            chk("pslverr", {31'h0, apb_q[0][64]}, {31'h0, pslverr});
            chk("prdata", apb_q[0][31:0], prdata & apb_q[0][63:32]);
            void'(apb_q.pop_front());
         end
      end
   end
   // core monitor: words leave in the order they arrived
   always @(posedge pclk) begin
      if (core_valid === 1'b1) begin
         if (core_q.size() == 0)
            chk("core extra", 0, 1);
         else
            chk("core_data", core_q.pop_front(), core_data);
      end
   end

   // watchdog
   initial begin
      #1_000_000;
      mismatches++;
      final_report();
   end

   initial begin
      seed = 32'h8808_90f8;
      {presetn, psel, penable, pwrite, rx_byte_shift, rate_fast} = 6'h00;
      paddr  = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`RED_OFF_RATIO, '1, 32'h0);
      rd(`RED_OFF_IRQ_MASK, 32'h3, 32'h0);
      rd(`RED_OFF_LATENCY, '1, LAT0);
      apb(1'b0, 8'h54, 0, '1, 0, 1'b1);
      apb(1'b1, 8'h3E, 32'h5, 0, 0, 1'b1);
      rate_fast     <= 1'b1;
      rx_byte_shift <= 1'b1;
      wr(`RED_OFF_RATIO, 32'h2);
      rd(`RED_OFF_RATIO, '1, 32'h2);
      rd(`RED_OFF_LATENCY, '1, LAT1);
      // random words with random gaps cross into the core domain
      for (i = 0; i < 40; i++) begin
         w = $random(seed);
         core_q.push_back(w);
         u_src.send(w);
         if (w[0])
            u_src.idle();
      end
      u_src.idle();
      n = 0;
      while (core_q.size() != 0 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk("words left", 0, 32'(core_q.size()));
      rd(`RED_OFF_FILL, 32'h0000_011F, 32'h100);
      // poll status until a measurement is published; mask still clear
      n = 0;
      do begin
         rd(`RED_OFF_IRQ_STAT, 0, 0);
         n++;
      end while (!last_rd[0] && n < 100);
      chk("new measurement", 1, {31'h0, last_rd[0]});
      chk("irq masked", 0, {31'h0, irq});
      rd(`RED_OFF_DELAY, 0, 0);
      chk("fresh", 1, {31'h0, last_rd[31]});
      chk("delay span", 1, {31'h0, last_rd[23:1] >= 23'd2
         && last_rd[23:1] <= 23'd16});
      rd(`RED_OFF_DELAY, 32'h8000_0000, 0);
      wr(`RED_OFF_IRQ_MASK, 32'h1);
      wait_irq(1'b1);
      wr(`RED_OFF_IRQ_STAT, 32'h1);
      wait_irq(1'b0);
      rd(`RED_OFF_IRQ_STAT, 32'h1, 0);
      wr(`RED_OFF_IRQ_MASK, 32'h0);
      repeat (4) @(posedge pclk);
      final_report();
   end
endmodule // test_rx_elastic_delay_measure
`default_nettype wire
